// >>> logic/adc_port_regs.vh
// Operation
// - After reset the next bits shifted in form a command byte.
// - The command byte picks the register and the direction of the next transfer.
// - Data enters only on the input line, leaves only on the output line.
// - Ready line goes low once a new word sits in the data register.
// - Ready line returns high when a data register read completes.
// - Ready line goes high before the data register is updated.
// - The port takes part in transfers only while select is low.
// - The same data word may be read again after a completed read.
// - Reading the command register returns the ready state in its top bit.
// - When select reasserts during a read, the bit that was on the output is driven again.
// - The reset input returns the serial interface to its initial state.
// - Thirty-two serial clocks with input high return the port to command wait.
// - Recovery by a run of ones clears only interface state; ones that complete a command or a write still take effect.
// - Six registers are reachable, each through a prior command write.
// - No full duplex: output idle during writes, input ignored during reads.
// - Right after the eighth command clock the selected transfer can begin.
// - Registers are 8 bits; data is 16 bits; offset and gain are 24 bits.
`ifndef ADC_PORT_REGS_VH
`define ADC_PORT_REGS_VH
// Command byte layout.
`define CMD_FLAG_BIT 7
`define CMD_SEL_HI 6
`define CMD_SEL_LO 4
`define CMD_READ_BIT 3
`define CMD_STBY_BIT 2
`define CMD_CHAN_HI 1
`define CMD_CHAN_LO 0
// Register select codes.
`define SEL_COMM 3'h0
`define SEL_SETUP 3'h1
`define SEL_CLOCK 3'h2
`define SEL_DATA 3'h3
`define SEL_OFFSET 3'h6
`define SEL_GAIN 3'h7
// Register lengths in bits.
`define LEN_BYTE 5'h08
`define LEN_DATA 5'h10
`define LEN_WIDE 5'h18
// Reset values.
`define RST_COMM 7'h00
`define RST_CHAN 2'h0
`define RST_SETUP 8'h00
`define RST_CLOCK 8'h00
`define RST_DATA 16'h0000
`define RST_OFFSET 24'h800000
`define RST_GAIN 24'h400000
// Run of ones that recovers the interface.
`define ONES_RESET_COUNT 6'h20
`endif

// >>> logic/word_fifo.v
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset.
   input wire clk_in,
   input wire rstn_in,
   // Fill side.
   input wire [WIDTH-1:0] in_data_in,
   input wire in_valid_in,
   output reg in_ready_out,
   // Drain side.
   output reg [WIDTH-1:0] out_data_out,
   output reg out_valid_out,
   input wire out_ready_in
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   reg [AW:0] count_next;
   wire push;
   wire pop;

   assign push = in_valid_in && in_ready_out;
   // The output register refills whenever it is empty or being taken.
   assign pop = (count_reg != {(AW+1){1'b0}}) && (!out_valid_out || out_ready_in);

   always @* begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
         count_next = count_reg - {{AW{1'b0}}, 1'b1};
      end
   end

   always @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data_in;
      end
   end

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
         in_ready_out <= 1'b0;
         out_valid_out <= 1'b0;
         out_data_out <= {WIDTH{1'b0}};
      end else begin
         count_reg <= count_next;
         in_ready_out <= (count_next != DEPTH[AW:0]);
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            out_data_out <= mem[rd_ptr_reg];
            out_valid_out <= 1'b1;
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// >>> logic/adc_serial_host_port.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_regs.vh"
module adc_serial_host_port #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // Clock and reset.
   input wire clk_in,
   input wire rstn_in,
   // Serial pins.
   input wire sclk_in,
   input wire cs_n_in,
   input wire din_in,
   output reg dout_out,
   output reg dout_oe_out,
   output reg data_ready_n_out,
   // Conversion words from the converter core.
   input wire [15:0] conv_word_in,
   input wire conv_valid_in,
   output wire conv_ready_out,
   // Settings towards the converter core.
   output reg [1:0] channel_out,
   output reg standby_out,
   output reg [7:0] setup_out,
   output reg [7:0] clock_out,
   output reg [23:0] offset_out,
   output reg [23:0] gain_out
);
   localparam S_CMD = 2'h0;
   localparam S_WR = 2'h1;
   localparam S_RD = 2'h2;
   localparam U_IDLE = 2'h0;
   localparam U_PREP = 2'h1;
   localparam U_SHOW = 2'h2;

   // Length in bits of the register named by a select code.
   function [4:0] reg_len;
      input [2:0] sel;
      begin
         case (sel)
            `SEL_DATA: reg_len = `LEN_DATA;
            `SEL_OFFSET: reg_len = `LEN_WIDE;
            `SEL_GAIN: reg_len = `LEN_WIDE;
            default: reg_len = `LEN_BYTE;
         endcase
      end
   endfunction

   reg sclk_s1, sclk_s2, sclk_d3;
   reg cs_s1, cs_s2;
   reg din_s1, din_s2;
   reg [1:0] st_reg;
   reg [2:0] sel_reg;
   reg [4:0] bit_cnt_reg;
   reg [5:0] ones_cnt_reg;
   reg [23:0] in_sr_reg;
   reg [23:0] out_sr_reg;
   reg pending_reg;
   reg read_done_reg;
   reg [6:0] comm_reg;
   reg [15:0] data_reg;
   reg [1:0] upd_reg;
   reg [23:0] rd_value;
   wire sclk_rise;
   wire sclk_fall;
   wire cs_act;
   wire [23:0] in_word;
   wire [7:0] cmd_byte;
   wire [4:0] cur_len;
   wire [4:0] cmd_len;
   wire [15:0] fifo_data;
   wire fifo_valid;
   wire fifo_ready;
   wire data_busy;

   // Pins are brought into the clock domain through two flip-flops.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_d3 <= 1'b1;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         sclk_s1 <= sclk_in;
         sclk_s2 <= sclk_s1;
         sclk_d3 <= sclk_s2;
         cs_s1 <= cs_n_in;
         cs_s2 <= cs_s1;
         din_s1 <= din_in;
         din_s2 <= din_s1;
      end
   end

   assign sclk_rise = sclk_s2 && !sclk_d3;
   assign sclk_fall = !sclk_s2 && sclk_d3;
   assign cs_act = !cs_s2;
   assign in_word = {in_sr_reg[22:0], din_s2};
   assign cmd_byte = in_word[7:0];
   assign cur_len = reg_len(sel_reg);
   assign cmd_len = reg_len(cmd_byte[`CMD_SEL_HI:`CMD_SEL_LO]);
   assign data_busy = (st_reg == S_RD) && (sel_reg == `SEL_DATA);

   // Value of the register a new read command names, MSB at bit 23.
   always @* begin
      case (cmd_byte[`CMD_SEL_HI:`CMD_SEL_LO])
         `SEL_COMM: rd_value = {data_ready_n_out, cmd_byte[6:0], 16'h0000};
         `SEL_SETUP: rd_value = {setup_out, 16'h0000};
         `SEL_CLOCK: rd_value = {clock_out, 16'h0000};
         `SEL_DATA: rd_value = {data_reg, 8'h00};
         `SEL_OFFSET: rd_value = offset_out;
         `SEL_GAIN: rd_value = gain_out;
         default: rd_value = 24'h000000;
      endcase
   end

   // Serial engine and the registers it writes.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg <= S_CMD;
         sel_reg <= `SEL_COMM;
         bit_cnt_reg <= 5'h00;
         ones_cnt_reg <= 6'h00;
         in_sr_reg <= 24'h000000;
         out_sr_reg <= 24'h000000;
         pending_reg <= 1'b0;
         read_done_reg <= 1'b0;
         dout_out <= 1'b0;
         dout_oe_out <= 1'b0;
         comm_reg <= `RST_COMM;
         setup_out <= `RST_SETUP;
         clock_out <= `RST_CLOCK;
         offset_out <= `RST_OFFSET;
         gain_out <= `RST_GAIN;
         channel_out <= `RST_CHAN;
         standby_out <= 1'b0;
      end else begin
         read_done_reg <= 1'b0;
         channel_out <= comm_reg[`CMD_CHAN_HI:`CMD_CHAN_LO];
         standby_out <= comm_reg[`CMD_STBY_BIT];
         // Output only drives during a selected read.
         dout_oe_out <= cs_act && (st_reg == S_RD);
         // The line follows the top of the shift register, so a reselect restores the bit.
         dout_out <= cs_act && (st_reg == S_RD) && out_sr_reg[23];
         if (sclk_rise && cs_act) begin
            if (din_s2 && ones_cnt_reg == `ONES_RESET_COUNT - 6'h01) begin
               // Only the interface state is cleared here.
               st_reg <= S_CMD;
               bit_cnt_reg <= 5'h00;
               ones_cnt_reg <= 6'h00;
               pending_reg <= 1'b0;
            end else begin
               ones_cnt_reg <= din_s2 ? ones_cnt_reg + 6'h01 : 6'h00;
               case (st_reg)
                  S_CMD: begin
                     in_sr_reg <= in_word;
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     if (bit_cnt_reg == 5'h07) begin
                        bit_cnt_reg <= 5'h00;
                        // A byte with its top bit set is not a command.
                        if (!cmd_byte[`CMD_FLAG_BIT]) begin
                           comm_reg <= cmd_byte[6:0];
                           sel_reg <= cmd_byte[`CMD_SEL_HI:`CMD_SEL_LO];
                           if (cmd_byte[`CMD_READ_BIT]) begin
                              st_reg <= S_RD;
                              out_sr_reg <= rd_value;
                              pending_reg <= 1'b0;
                           end else if (cmd_byte[`CMD_SEL_HI:`CMD_SEL_LO] != `SEL_COMM) begin
                              st_reg <= S_WR;
                           end
                        end
                     end
                  end
                  S_WR: begin
                     in_sr_reg <= in_word;
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     if (bit_cnt_reg == cur_len - 5'h01) begin
                        bit_cnt_reg <= 5'h00;
                        st_reg <= S_CMD;
                        case (sel_reg)
                           `SEL_SETUP: setup_out <= in_word[7:0];
                           `SEL_CLOCK: clock_out <= in_word[7:0];
                           `SEL_OFFSET: offset_out <= in_word;
                           `SEL_GAIN: gain_out <= in_word;
                           default: comm_reg <= comm_reg;
                        endcase
                     end
                  end
                  S_RD: begin
                     // Input bits are ignored while reading.
                     bit_cnt_reg <= bit_cnt_reg + 5'h01;
                     pending_reg <= 1'b1;
                     if (bit_cnt_reg == cur_len - 5'h01) begin
                        bit_cnt_reg <= 5'h00;
                        st_reg <= S_CMD;
                        pending_reg <= 1'b0;
                        read_done_reg <= (sel_reg == `SEL_DATA);
                     end
                  end
                  default: st_reg <= S_CMD;
               endcase
            end
         end else if (sclk_fall && cs_act && st_reg == S_RD && pending_reg) begin
            out_sr_reg <= {out_sr_reg[22:0], 1'b0};
            pending_reg <= 1'b0;
         end else if (sclk_rise && !cs_act) begin
            ones_cnt_reg <= ones_cnt_reg;
         end
      end
   end

   word_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .in_data_in(conv_word_in),
      .in_valid_in(conv_valid_in),
      .in_ready_out(conv_ready_out),
      .out_data_out(fifo_data),
      .out_valid_out(fifo_valid),
      .out_ready_in(fifo_ready)
   );

   // The drain side stalls while the data register is being read.
   assign fifo_ready = (upd_reg == U_PREP);

   // Output register update sequence.
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         upd_reg <= U_IDLE;
         data_reg <= `RST_DATA;
         data_ready_n_out <= 1'b1;
      end else begin
         case (upd_reg)
            U_IDLE: begin
               if (read_done_reg) begin
                  data_ready_n_out <= 1'b1;
               end
               if (fifo_valid && !data_busy) begin
                  data_ready_n_out <= 1'b1;
                  upd_reg <= U_PREP;
               end
            end
            U_PREP: begin
               data_ready_n_out <= 1'b1;
               data_reg <= fifo_data;
               upd_reg <= U_SHOW;
            end
            U_SHOW: begin
               data_ready_n_out <= 1'b0;
               upd_reg <= U_IDLE;
            end
            default: upd_reg <= U_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> sim/adc_port_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module adc_port_checker #(
   parameter FIFO_DEPTH = 8,
   parameter FIFO_AW = 3
) (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rstn_in,
   // Serial pins.
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic dout_out,
   input wire logic dout_oe_out,
   input wire logic data_ready_n_out,
   // Converter side.
   input wire logic conv_valid_in,
   input wire logic conv_ready_out,
   // Settings.
   input wire logic [1:0] channel_out,
   input wire logic standby_out,
   input wire logic [7:0] setup_out,
   input wire logic [7:0] clock_out,
   input wire logic [23:0] offset_out,
   input wire logic [23:0] gain_out
);
   wire logic [66:0] all_regs = {setup_out, clock_out, offset_out, gain_out, channel_out,
      standby_out};
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   cs_float_a: assert property (cs_n_in [*6] |-> !dout_oe_out)
      else $error("output enabled while deselected");
   idle_low_a: assert property (!dout_oe_out |-> !dout_out)
      else $error("output not idle while released");
   regs_hold_a: assert property (cs_n_in [*8] |-> $stable(all_regs))
      else $error("settings changed while deselected");
   clock_cause_a: assert property (!$stable(all_regs) |-> $past(sclk_in, 2) || $past(sclk_in, 3))
      else $error("settings changed without a serial clock");
   word_ready_a: assert property (conv_valid_in && conv_ready_out && cs_n_in |-> ##[1:12] !data_ready_n_out)
      else $error("new word not announced");
   ready_prep_a: assert property ($fell(data_ready_n_out) |-> $past(data_ready_n_out, 2))
      else $error("ready fell without a high spell first");
   conv_start_a: assert property ($past(rstn_in) && !$past(rstn_in, 2) |-> conv_ready_out)
      else $error("buffer not ready after reset");
   oe_select_a: assert property ($rose(dout_oe_out) |-> $past(!cs_n_in, 2))
      else $error("output enabled without select");
   cover property ($fell(data_ready_n_out));
   cover property ($rose(dout_oe_out));
   cover property (conv_valid_in && !conv_ready_out);
endmodule
bind adc_serial_host_port adc_port_checker #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_checker (
   .clk_in, .rstn_in, .sclk_in, .cs_n_in, .dout_out, .dout_oe_out, .data_ready_n_out,
   .conv_valid_in, .conv_ready_out, .channel_out, .standby_out, .setup_out, .clock_out,
   .offset_out, .gain_out);
`default_nettype wire

// >>> sim/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   // Pins towards the port.
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out,
   // Pins from the port.
   input wire logic dout_in,
   input wire logic dout_oe_in
);
   logic hold_cs = 1'b0;
   logic seen_oe = 1'b0;
   initial begin
      sclk_out = 1'b1;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   end
   // A pause at bit brk deselects the port and keeps clocking, which it must ignore.
   task automatic shift(input int n, input logic [23:0] tx, input logic rd, input int brk,
                        output logic [23:0] rx);
      rx = 24'h0;
      for (int i = n - 1; i >= 0; i--) begin
         if (i == brk) begin
            cs_n_out = 1'b1;
            repeat (6) begin
               sclk_out = ~sclk_out;
               din_out = ~din_out;
               #100;
            end
            cs_n_out = 1'b0;
            #100;
         end
         sclk_out = 1'b0;
         din_out = rd ? ~din_out : tx[i];
         #100;
         sclk_out = 1'b1;
         seen_oe = seen_oe | dout_oe_in;
         rx = {rx[22:0], dout_in};
         #100;
      end
   endtask
   task automatic frame(input logic [7:0] cmd, input int n, input logic [23:0] tx, input int brk,
                        output logic [23:0] rx);
      #7;
      seen_oe = 1'b0;
      cs_n_out = 1'b0;
      #100;
      shift(8, {16'h0, cmd}, 1'b0, -1, rx);
      shift(n, tx, cmd[3], brk, rx);
      #100;
      if (!hold_cs) begin
         cs_n_out = 1'b1;
      end
      din_out = ~din_out;
   endtask
   // Lost-interface recovery for a shared data line: 24 clocks with the input low, then 32 ones.
   task automatic recover();
      #7;
      cs_n_out = 1'b0;
      din_out = 1'b0;
      #100;
      repeat (24) begin
         sclk_out = 1'b0;
         #100;
         sclk_out = 1'b1;
         #100;
      end
      din_out = 1'b1;
      repeat (32) begin
         sclk_out = 1'b0;
         #100;
         sclk_out = 1'b1;
         #100;
      end
      #100;
      cs_n_out = 1'b1;
      din_out = 1'b0;
   endtask
endmodule
`default_nettype wire

// >>> sim/adc_serial_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_host_port_tb;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [15:0] conv_word_in = 16'h0000;
   logic conv_valid_in = 1'b0;
   wire logic sclk, cs_n, din, dout, dout_oe, data_ready_n_n, conv_ready, standby;
   wire logic [1:0] channel;
   wire logic [7:0] setup_v, clock_v;
   wire logic [23:0] offset_v, gain_v;
   int miscompares = 0;
   int check_count = 0;
   int seed = 32'hbc6c19c8;
   logic [23:0] rd, val, keep;
   logic [15:0] lastw;
   logic [7:0] cmd;
   logic [2:0] sc = 3'h0;
   logic low_seen;
   logic [23:0] exp_val [0:7];
   always #12.5 clk_in = ~clk_in;
   adc_serial_host_port #(.FIFO_DEPTH(8), .FIFO_AW(3)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
      .sclk_in(sclk), .cs_n_in(cs_n), .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe),
      .data_ready_n_out(data_ready_n_n), .conv_word_in(conv_word_in), .conv_valid_in(conv_valid_in),
      .conv_ready_out(conv_ready), .channel_out(channel), .standby_out(standby),
      .setup_out(setup_v), .clock_out(clock_v), .offset_out(offset_v), .gain_out(gain_v));
   serial_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout),
      .dout_oe_in(dout_oe));
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] want);
      check_count++;
      if (seen !== want) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function automatic int len_of(input logic [2:0] s);
      return (s[2:1] == 2'b11) ? 24 : (s == 3'h3) ? 16 : 8;
   endfunction
   function automatic logic [23:0] fit(input logic [2:0] s, input logic [23:0] v);
      return v & ((24'h1 << len_of(s)) - 24'h1);
   endfunction
   function automatic logic [2:0] pick(input logic [1:0] r);
      case (r)
         2'h0: return 3'h1;
         2'h1: return 3'h2;
         2'h2: return 3'h6;
         default: return 3'h7;
      endcase
   endfunction
   function automatic logic [23:0] port_val(input logic [2:0] s);
      case (s)
         3'h1: return {16'h0, setup_v};
         3'h2: return {16'h0, clock_v};
         3'h6: return offset_v;
         default: return gain_v;
      endcase
   endfunction
   task automatic xfer(input logic [2:0] s, input logic r, input logic [23:0] w, input int brk);
      cmd = {1'b0, s, r, sc};
      u_host.frame(cmd, len_of(s), w, brk, rd);
      check("output enable", 24'(u_host.seen_oe), 24'(r));
   endtask
   task automatic do_reset();
      @(negedge clk_in);
      rstn_in = 1'b0;
      repeat (3) @(negedge clk_in);
      rstn_in = 1'b1;
      repeat (4) @(negedge clk_in);
      check("setup", 24'(setup_v), 24'h0);
      check("clock", 24'(clock_v), 24'h0);
      check("offset", offset_v, 24'h800000);
      check("gain", gain_v, 24'h400000);
      check("data_ready_n", 24'(data_ready_n_n), 24'h1);
   endtask
   task automatic wr_rd(input logic [2:0] s);
      sc = 3'($random(seed));
      val = fit(s, 24'($random(seed)));
      exp_val[s] = val;
      xfer(s, 1'b0, val, s[2] ? 11 : -1);
      repeat (6) @(negedge clk_in);
      check("setting", port_val(s), val);
      check("mode", 24'({standby, channel}), 24'(sc));
      xfer(s, 1'b1, 24'h0, s[2] ? 11 : -1);
      check("readback", rd, val);
   endtask
   task automatic push(input logic [15:0] w);
      @(negedge clk_in);
      conv_word_in = w;
      conv_valid_in = 1'b1;
      @(negedge clk_in);
      conv_valid_in = 1'b0;
   endtask
   task automatic wait_rdy(input logic want);
      int n;
      n = 0;
      while (data_ready_n_n !== want && n < 200) begin
         @(negedge clk_in);
         n++;
      end
      check("data_ready_n", 24'(data_ready_n_n), 24'(want));
   endtask
   // About thirty frames of under 8 us each and one recovery fit well inside this span.
   initial begin
      #1000000;
      miscompares++;
      results();
   end
   initial begin
      do_reset();
      u_host.hold_cs = 1'b1;
      sc = 3'h5;
      xfer(3'h0, 1'b1, 24'h0, -1);
      check("comm readback", rd, {16'h0, 1'b1, cmd[6:0]});
      u_host.hold_cs = 1'b0;
      $display("test three_wire done");
      wr_rd(3'h1);
      wr_rd(3'h2);
      wr_rd(3'h6);
      wr_rd(3'h7);
      repeat (8) wr_rd(pick(2'($random(seed))));
      $display("test registers done");
      lastw = 16'($random(seed));
      push(lastw);
      wait_rdy(1'b0);
      xfer(3'h3, 1'b1, 24'h0, -1);
      check("data word", rd, {8'h0, lastw});
      wait_rdy(1'b1);
      repeat (4) @(negedge clk_in);
      xfer(3'h3, 1'b1, 24'h0, -1);
      check("data again", rd, {8'h0, lastw});
      $display("test data done");
      u_host.frame({1'b0, 3'h1, 1'b1, 3'h0}, 3, 24'h0, -1, rd);
      u_host.recover();
      repeat (6) @(negedge clk_in);
      check("kept setup", port_val(3'h1), exp_val[1]);
      check("kept clock", port_val(3'h2), exp_val[2]);
      check("kept offset", port_val(3'h6), exp_val[6]);
      check("kept gain", port_val(3'h7), exp_val[7]);
      wr_rd(3'h1);
      $display("test recovery done");
      do_reset();
      wr_rd(3'h6);
      $display("test reset done");
      results();
   end
endmodule
`default_nettype wire
